//--- src/smsq_pkg.sv
// shared constants for the two-wire status sequencer controller
// Operation
// - software acknowledge bit used, hardware ack off
// - after start 1110, send address, expect 1100
// - in 1100 start restarts, stop aborts
// - in 1100 next byte returns to 1100
// - in 1100 stop alone ends transfer
// - start plus stop gives stop then start
// - clear event without data gives receive 1000
// - in 1000 ack one keeps receiving
// - nack with stop ends read
// - nack with start and stop restarts, 1110
// - ack with start gives repeated start, 1110
// - nack with start gives repeated start, 1110
// - data written first switches to transmit, 1100
// - touch shift data only while event set
package smsq_pkg;

  localparam int          DW          = 8;
  localparam logic        ADDR_CTRL   = 1'b0;
  localparam logic        ADDR_DATA   = 1'b1;
  localparam int          BIT_ROLE    = 7;
  localparam int          BIT_TXD     = 6;
  localparam int          BIT_STA     = 5;
  localparam int          BIT_STO     = 4;
  localparam int          BIT_ACK_REQUESTED_FLAG   = 3;
  localparam int          BIT_ARB     = 2;
  localparam int          BIT_ACK     = 1;
  localparam int          BIT_EVT     = 0;
  localparam logic [3:0]  V_START     = 4'hE;
  localparam logic [3:0]  V_MTX       = 4'hC;
  localparam logic [3:0]  V_MRX       = 4'h8;
  localparam logic [3:0]  V_NONE      = 4'h0;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam int          FIFO_DEPTH  = 2;

  typedef enum logic [2:0] {
    OP_START      = 3'h0,
    OP_WRITE      = 3'h1,
    OP_READ       = 3'h2,
    OP_STOP       = 3'h3,
    OP_STOP_START = 3'h4,
    OP_RESTART    = 3'h5
  } smsq_op_t;

endpackage : smsq_pkg

//--- src/smsq_sync.sv
// two-flop synchroniser for inputs from the device
`timescale 1ns/100ps
module smsq_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d_i;
      q_r    <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule : smsq_sync

//--- src/smsq_fifo.sv
// shift-register buffer, head always in slot zero
`timescale 1ns/100ps
module smsq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem_r   [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [DEPTH-1:0] vld_r;
  logic [DEPTH-1:0] vld_nxt;
  logic             push;
  logic             pop;

  // full is the last slot taken, so no push on full even with pop
  assign in_ready_o  = ~vld_r[DEPTH-1];
  assign out_valid_o = vld_r[0];
  assign out_data_o  = mem_r[0];
  assign push        = in_valid_i & ~vld_r[DEPTH-1];
  assign pop         = vld_r[0] & out_ready_i;

  always_comb begin
    logic placed;
    placed  = 1'b0;
    mem_nxt = mem_r;
    vld_nxt = vld_r;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        mem_nxt[i] = mem_r[i+1];
        vld_nxt[i] = vld_r[i+1];
      end
      vld_nxt[DEPTH-1] = 1'b0;
    end
    if (push) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!placed && !vld_nxt[i]) begin
          mem_nxt[i] = in_data_i;
          vld_nxt[i] = 1'b1;
          placed     = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vld_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      vld_r <= vld_nxt;
      mem_r <= mem_nxt;
    end
  end
endmodule : smsq_fifo

//--- src/smsq_ctrl.sv
// controller that steps the device through master transfers
`timescale 1ns/100ps
module smsq_ctrl (
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  input  wire logic               cmd_valid_i,
  input  wire smsq_pkg::smsq_op_t cmd_op_i,
  input  wire logic [7:0]         cmd_data_i,
  input  wire logic               cmd_ack_i,
  output logic                    cmd_ready_o,
  output logic                    rx_valid_o,
  output logic [7:0]              rx_data_o,
  input  wire logic               rx_ready_i,
  output logic [3:0]              status_o,
  output logic                    tx_nack_o,
  output logic                    busy_o,
  output logic                    err_o,
  output logic                    dev_req_o,
  output logic                    dev_we_o,
  output logic                    dev_addr_o,
  output logic [7:0]              dev_wdata_o,
  input  wire logic               dev_ack_i,
  input  wire logic [7:0]         dev_rdata_i,
  input  wire logic               dev_evt_i
);
  import smsq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // types and decode helpers

  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_CMD      = 4'h1,
    S_WR_DATA  = 4'h2,
    S_WR_CTRL  = 4'h3,
    S_WAIT_EVT = 4'h4,
    S_RD_STAT  = 4'h5,
    S_RD_DATA  = 4'h6,
    S_PUSH     = 4'h7
  } smsq_state_t;

  typedef enum logic [1:0] {
    B_IDLE = 2'h0,
    B_REQ  = 2'h1,
    B_REL  = 2'h2
  } smsq_bus_t;

  // vector expected after the control write for each order
  function automatic logic [3:0] next_vec(input smsq_op_t op);
    case (op)
      OP_START:      next_vec = V_START;
      OP_WRITE:      next_vec = V_MTX;
      OP_READ:       next_vec = V_MRX;
      OP_STOP:       next_vec = V_NONE;
      OP_STOP_START: next_vec = V_START;
      OP_RESTART:    next_vec = V_START;
      default:       next_vec = V_NONE;
    endcase
  endfunction : next_vec

  // which orders make sense at which vector
  function automatic logic legal(input logic [3:0] v, input smsq_op_t op);
    case (v)
      V_NONE:  legal = (op == OP_START);
      V_START: legal = (op == OP_WRITE);
      V_MTX:   legal = (op != OP_START);
      V_MRX:   legal = (op != OP_START);
      default: legal = 1'b0;
    endcase
  endfunction : legal

  // control byte: event bit always written zero to release the device
  function automatic logic [7:0] ctl_byte(input smsq_op_t op,
                                          input logic ack);
    logic [7:0] b;
    b = RST_BYTE;
    b[BIT_STA] = (op == OP_START) || (op == OP_STOP_START) ||
                 (op == OP_RESTART);
    b[BIT_STO] = (op == OP_STOP) || (op == OP_STOP_START);
    b[BIT_ACK] = ack;
    ctl_byte = b;
  endfunction : ctl_byte

  ////////////////////////////////////////////////////////////////////////
  // device inputs cross into our clock

  logic       ack_s;
  logic       evt_s;
  logic [7:0] rdata_s;

  smsq_sync #(
    .W (10)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .d_i        ({dev_ack_i, dev_evt_i, dev_rdata_i}),
    .q_o        ({ack_s, evt_s, rdata_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // register access handshake: four-phase req/ack

  smsq_state_t st_r;
  smsq_state_t st_nxt;
  smsq_bus_t   b_st_r;
  smsq_bus_t   b_st_nxt;
  logic        req_r, req_nxt;
  logic        we_r, we_nxt;
  logic        addr_r, addr_nxt;
  logic [7:0]  wd_r, wd_nxt;
  logic [7:0]  rd_r, rd_nxt;
  logic        b_go;
  logic        b_done;
  logic        acc_st;
  smsq_op_t    op_r, op_nxt;
  logic [7:0]  data_r, data_nxt;
  logic        ack_r, ack_nxt;

  assign acc_st = (st_r == S_WR_DATA) || (st_r == S_WR_CTRL) ||
                  (st_r == S_RD_STAT) || (st_r == S_RD_DATA);
  assign b_go   = acc_st && (b_st_r == B_IDLE);
  assign b_done = (b_st_r == B_REL) && !ack_s;

  always_comb begin
    b_st_nxt = b_st_r;
    req_nxt  = req_r;
    we_nxt   = we_r;
    addr_nxt = addr_r;
    wd_nxt   = wd_r;
    rd_nxt   = rd_r;
    case (b_st_r)
      B_IDLE: begin
        if (b_go) begin
          b_st_nxt = B_REQ;
          req_nxt  = 1'b1;
          we_nxt   = (st_r == S_WR_DATA) || (st_r == S_WR_CTRL);
          addr_nxt = (st_r == S_WR_DATA) || (st_r == S_RD_DATA);
          wd_nxt   = (st_r == S_WR_DATA) ? data_r : ctl_byte(op_r, ack_r);
        end
      end
      B_REQ: begin
        // device keeps read data steady while its ack is high
        if (ack_s) begin
          b_st_nxt = B_REL;
          req_nxt  = 1'b0;
          rd_nxt   = rdata_s;
        end
      end
      B_REL: begin
        if (!ack_s) begin
          b_st_nxt = B_IDLE;
        end
      end
      default: begin
        b_st_nxt = B_IDLE;
        req_nxt  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      b_st_r <= B_IDLE;
      req_r  <= 1'b0;
      we_r   <= 1'b0;
      addr_r <= ADDR_CTRL;
      wd_r   <= RST_BYTE;
      rd_r   <= RST_BYTE;
    end else begin
      b_st_r <= b_st_nxt;
      req_r  <= req_nxt;
      we_r   <= we_nxt;
      addr_r <= addr_nxt;
      wd_r   <= wd_nxt;
      rd_r   <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer sequencer

  logic [3:0] vec_r, vec_nxt;
  logic [3:0] exp_r, exp_nxt;
  logic       dwr_r, dwr_nxt;
  logic       nack_r, nack_nxt;
  logic       err_r, err_nxt;
  logic       rdy_r, rdy_nxt;
  logic       busy_r, busy_nxt;
  logic [7:0] rxb_r, rxb_nxt;
  logic       cmd_fire;
  logic       fifo_in_ready;
  logic       bad_stat;

  assign cmd_fire = cmd_valid_i && rdy_r;
  // arbitration loss is a fault here
  assign bad_stat = (rd_r[7:4] != exp_r) || rd_r[BIT_ARB] ||
                    ((rd_r[7:4] == V_MRX) && !rd_r[BIT_ACK_REQUESTED_FLAG]);

  always_comb begin
    st_nxt   = st_r;
    op_nxt   = op_r;
    data_nxt = data_r;
    ack_nxt  = ack_r;
    vec_nxt  = vec_r;
    exp_nxt  = exp_r;
    dwr_nxt  = dwr_r;
    nack_nxt = nack_r;
    rxb_nxt  = rxb_r;
    err_nxt  = 1'b0;
    case (st_r)
      S_IDLE, S_CMD: begin
        if (cmd_fire) begin
          op_nxt   = cmd_op_i;
          data_nxt = cmd_data_i;
          ack_nxt  = cmd_ack_i;
          if (!legal(vec_r, cmd_op_i)) begin
            err_nxt = 1'b1;
          end else if (cmd_op_i == OP_WRITE) begin
            st_nxt = S_WR_DATA;
          end else begin
            st_nxt = S_WR_CTRL;
          end
        end
      end
      S_WR_DATA: begin
        if (b_done) begin
          dwr_nxt = 1'b1;
          st_nxt  = S_WR_CTRL;
        end
      end
      S_WR_CTRL: begin
        if (b_go) begin
          exp_nxt = next_vec(op_r);
        end
        if (b_done) begin
          dwr_nxt = 1'b0;
          if (exp_r == V_NONE) begin
            vec_nxt = V_NONE;
            st_nxt  = S_IDLE;
          end else begin
            st_nxt = S_WAIT_EVT;
          end
        end
      end
      S_WAIT_EVT: begin
        // ack order means the old flag is already seen low here
        if (evt_s) begin
          st_nxt = S_RD_STAT;
        end
      end
      S_RD_STAT: begin
        if (b_done) begin
          vec_nxt  = rd_r[7:4];
          nack_nxt = (rd_r[7:4] == V_MTX) && !rd_r[BIT_ACK];
          if (bad_stat) begin
            err_nxt = 1'b1;
            vec_nxt = V_NONE;
            st_nxt  = S_IDLE;
          end else if (rd_r[7:4] == V_MRX) begin
            st_nxt = S_RD_DATA;
          end else begin
            st_nxt = S_CMD;
          end
        end
      end
      S_RD_DATA: begin
        // byte kept as shifted, msb first
        if (b_done) begin
          rxb_nxt = rd_r;
          st_nxt  = S_PUSH;
        end
      end
      S_PUSH: begin
        // a full buffer holds the bus: event stays set until room
        if (fifo_in_ready) begin
          st_nxt = S_CMD;
        end
      end
      default: begin
        st_nxt  = S_IDLE;
        vec_nxt = V_NONE;
      end
    endcase
    rdy_nxt  = (st_nxt == S_IDLE) || (st_nxt == S_CMD);
    busy_nxt = (st_nxt != S_IDLE);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r   <= S_IDLE;
      op_r   <= OP_START;
      data_r <= RST_BYTE;
      ack_r  <= 1'b0;
      vec_r  <= V_NONE;
      exp_r  <= V_NONE;
      dwr_r  <= 1'b0;
      nack_r <= 1'b0;
      rxb_r  <= RST_BYTE;
      err_r  <= 1'b0;
      rdy_r  <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      op_r   <= op_nxt;
      data_r <= data_nxt;
      ack_r  <= ack_nxt;
      vec_r  <= vec_nxt;
      exp_r  <= exp_nxt;
      dwr_r  <= dwr_nxt;
      nack_r <= nack_nxt;
      rxb_r  <= rxb_nxt;
      err_r  <= err_nxt;
      rdy_r  <= rdy_nxt;
      busy_r <= busy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // received bytes to the user

  smsq_fifo #(
    .WIDTH (DW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (st_r == S_PUSH),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rxb_r),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o)
  );

  assign cmd_ready_o = rdy_r;
  assign status_o    = vec_r;
  assign tx_nack_o   = nack_r;
  assign busy_o      = busy_r;
  assign err_o       = err_r;
  assign dev_req_o   = req_r;
  assign dev_we_o    = we_r;
  assign dev_addr_o  = addr_r;
  assign dev_wdata_o = wd_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic ctl_go;
  assign ctl_go = b_go && (st_r == S_WR_CTRL);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_data_gated: assert property (
    (dev_req_o && dev_addr_o == ADDR_DATA) |-> evt_s)
    else $error("shift data touched with event flag clear");
  a_start_addr: assert property (
    ctl_go && vec_r == V_START |=> !dev_wdata_o[BIT_STA] &&
      !dev_wdata_o[BIT_STO] && exp_r == V_MTX)
    else $error("address phase control write wrong");
  a_tx_restart: assert property (
    ctl_go && vec_r == V_MTX && op_r == OP_RESTART |=>
      dev_wdata_o[BIT_STA] && !dev_wdata_o[BIT_STO] && exp_r == V_START)
    else $error("restart from transmit wrong");
  a_tx_next_byte: assert property (
    ctl_go && vec_r == V_MTX && op_r == OP_WRITE |-> dwr_r ##1
      (dev_wdata_o[5:4] == 2'h0 && exp_r == V_MTX))
    else $error("next byte not loaded before release");
  a_tx_stop: assert property (
    ctl_go && op_r == OP_STOP |=> (dev_wdata_o[5:4] == 2'h1 &&
      st_r == S_WR_CTRL) ##[1:40] (st_r == S_IDLE && vec_r == V_NONE))
    else $error("stop did not end the transfer");
  a_tx_stop_start: assert property (
    ctl_go && vec_r == V_MTX && op_r == OP_STOP_START |=>
      dev_wdata_o[5:4] == 2'h3 && exp_r == V_START)
    else $error("stop then start wrong");
  a_to_receive: assert property (
    ctl_go && vec_r == V_MTX && op_r == OP_READ |-> !dwr_r ##1
      (dev_wdata_o[5:4] == 2'h0 && exp_r == V_MRX))
    else $error("switch to receive wrong");
  a_rx_ack_more: assert property (
    ctl_go && vec_r == V_MRX && op_r == OP_READ |=>
      dev_wdata_o[BIT_ACK] == $past(ack_r) && dev_wdata_o[5:4] == 2'h0)
    else $error("receive acknowledge write wrong");
  a_rx_nack_stop: assert property (
    ctl_go && vec_r == V_MRX && op_r == OP_STOP |=>
      dev_wdata_o[5:4] == 2'h1 && dev_wdata_o[BIT_EVT] == 1'b0)
    else $error("last byte stop wrong");
  a_rx_restart: assert property (
    ctl_go && vec_r == V_MRX &&
      (op_r == OP_RESTART || op_r == OP_STOP_START) |=>
      dev_wdata_o[BIT_STA] && exp_r == V_START)
    else $error("receive restart wrong");
  a_rx_to_tx: assert property (
    ctl_go && vec_r == V_MRX && op_r == OP_WRITE |-> dwr_r ##1
      exp_r == V_MTX)
    else $error("switch to transmit wrong");
  a_stat_bad: assert property (
    st_r == S_RD_STAT && b_done && rd_r[BIT_ARB] |=>
      err_o && st_r == S_IDLE)
    else $error("arbitration loss not flagged");
endmodule : smsq_ctrl

//--- verification/smsq_dev_model.sv
// behavioural device: status register, shift data and event flag
`timescale 1ns/100ps
module smsq_dev_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       req_i,
  input  wire logic       we_i,
  input  wire logic       addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       slow_i,
  input  wire logic       nack_i,
  input  wire logic       arb_i,
  output logic            ack_o,
  output logic            evt_o,
  output logic            last_ack_o,
  output logic            bad_o,
  output logic [7:0]      rdata_o
);
  import smsq_pkg::*;
  logic [3:0] vec_r;
  logic [7:0] dat_r;
  logic [7:0] rx_n_r;
  logic       rq_r;
  logic       arb_r;
  logic       ab_r;
  logic       wr_r;
  logic       pend_r;
  int         hs_r;
  int         ev_r;
  int         dly;
  logic       start_request_bit;
  logic       stop_request_bit;
  assign dly = slow_i ? 7 : 1;
  assign start_request_bit = wdata_i[BIT_STA];
  assign stop_request_bit = wdata_i[BIT_STO];
  //////////////////////////////////////////////////////////////////////
  always @(negedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {vec_r, rq_r, arb_r, ab_r, wr_r, pend_r} <= '0;
      {ack_o, evt_o, last_ack_o, bad_o} <= '0;
      dat_r <= RST_BYTE;
      rx_n_r <= 8'h00;
      rdata_o <= 8'hFF;
      hs_r <= 0;
      ev_r <= 0;
    end else if (ack_o) begin
      // released bus shows the inverse, never the stale byte
      if (!req_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
      end
    end else if (req_i) begin
      hs_r <= hs_r + 1;
      if (hs_r == dly) begin
        hs_r <= 0;
        ack_o <= 1'b1;
        // shift data only while event set
        if (addr_i && !evt_o) bad_o <= 1'b1;
        if (!we_i && addr_i) rdata_o <= dat_r;
        // vector on top, arb lost bit
        if (!we_i && !addr_i) rdata_o <= {vec_r, rq_r, arb_r, ab_r, evt_o};
        if (we_i && addr_i) begin
          dat_r <= wdata_i;
          wr_r <= 1'b1;
        end
        if (we_i && !addr_i) begin
          // acts on the write that clears event
          evt_o <= 1'b0;
          wr_r <= 1'b0;
          pend_r <= !(stop_request_bit && !start_request_bit);
          arb_r <= arb_i;
          ab_r <= !nack_i;
          // ack bit from the software write
          last_ack_o <= wdata_i[BIT_ACK];
          if (stop_request_bit && !start_request_bit) vec_r <= V_NONE;
          else if (start_request_bit) vec_r <= V_START;
          else if (vec_r == V_START || wr_r) vec_r <= V_MTX;
          else begin
            vec_r <= V_MRX;
            dat_r <= 8'h3C + rx_n_r;
            rx_n_r <= rx_n_r + 8'h01;
          end
          rq_r <= !start_request_bit && !stop_request_bit && vec_r != V_START && !wr_r;
        end
      end
    end else if (pend_r) begin
      ev_r <= ev_r + 1;
      if (ev_r == dly) begin
        ev_r <= 0;
        pend_r <= 1'b0;
        evt_o <= 1'b1;
      end
    end
  end
endmodule : smsq_dev_model

//--- verification/smsq_ctrl_bench.sv
// self-checking bench for the status sequencer controller
`timescale 1ns/100ps
module smsq_ctrl_bench;
  import smsq_pkg::*;
  logic       clk = 0, rst = 1, cmd_valid = 0, cmd_ack = 0, rx_ready = 1;
  smsq_op_t   cmd_op = OP_START;
  logic [7:0] cmd_data = 8'h00, rx_data, wdata, rdata;
  logic [3:0] status;
  logic       cmd_ready, rx_valid, tx_nack, busy, err, req, we, addr;
  logic       dack, evt, slow = 0, nack = 0, arb = 0, last_ack, bad;
  int         err_count = 0, n_tests = 0, err_seen = 0, rx_k = 0;
  always #50 clk = ~clk;
  smsq_ctrl smsq_ctrl_inst (.core_clk_i(clk), .rst_i(rst),
    .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_data_i(cmd_data),
    .cmd_ack_i(cmd_ack), .cmd_ready_o(cmd_ready), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_ready_i(rx_ready), .status_o(status),
    .tx_nack_o(tx_nack), .busy_o(busy), .err_o(err), .dev_req_o(req),
    .dev_we_o(we), .dev_addr_o(addr), .dev_wdata_o(wdata),
    .dev_ack_i(dack), .dev_rdata_i(rdata), .dev_evt_i(evt));
  smsq_dev_model smsq_dev_model_inst (.clk_i(clk), .rst_i(rst),
    .req_i(req), .we_i(we), .addr_i(addr), .wdata_i(wdata),
    .slow_i(slow), .nack_i(nack), .arb_i(arb), .ack_o(dack),
    .evt_o(evt), .last_ack_o(last_ack), .bad_o(bad), .rdata_o(rdata));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task automatic wrap_up();
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 900 && cmd_ready !== 1'b1; i++) @(negedge clk);
    if (i == 900) begin
      chk("ready wait", 8'h01, 8'h00);
      wrap_up();
    end
  endtask : wait_rdy
  task automatic send(input smsq_op_t op, input logic [7:0] d,
                      input logic a);
    wait_rdy();
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_ack = a;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : send
  task automatic op(input smsq_op_t o, input logic [7:0] d,
                    input logic a, input logic [3:0] v);
    send(o, d, a);
    wait_rdy();
    chk("status", {4'h0, v}, {4'h0, status});
  endtask : op
  task automatic refuse(input smsq_op_t o);
    int e0;
    e0 = err_seen;
    send(o, 8'h00, 1'b0);
    repeat (2) @(negedge clk);
    chk("err pulses", 8'(e0 + 1), 8'(err_seen));
  endtask : refuse
  always @(posedge clk) begin
    if (err === 1'b1) err_seen++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      chk("rx byte", 8'h3C + 8'(rx_k), rx_data);
      rx_k++;
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic sc_write();
    op(OP_START, 8'h00, 1'b0, V_START);
    op(OP_WRITE, 8'hA0, 1'b0, V_MTX);
    op(OP_WRITE, 8'h5A, 1'b0, V_MTX);
    chk("tx nack", 8'h00, {7'h0, tx_nack});
    op(OP_STOP, 8'h00, 1'b0, V_NONE);
    chk("busy", 8'h00, {7'h0, busy});
  endtask : sc_write
  task automatic sc_restart();
    op(OP_START, 8'h00, 1'b0, V_START);
    op(OP_WRITE, 8'hA2, 1'b0, V_MTX);
    op(OP_RESTART, 8'h00, 1'b0, V_START);
    op(OP_WRITE, 8'hA2, 1'b0, V_MTX);
    op(OP_STOP_START, 8'h00, 1'b0, V_START);
    op(OP_WRITE, 8'hA2, 1'b0, V_MTX);
    op(OP_STOP, 8'h00, 1'b0, V_NONE);
  endtask : sc_restart
  task automatic sc_refuse();
    refuse(OP_WRITE);
    op(OP_START, 8'h00, 1'b0, V_START);
    refuse(OP_READ);
    chk("status", {4'h0, V_START}, {4'h0, status});
    op(OP_WRITE, 8'hA0, 1'b0, V_MTX);
    op(OP_STOP, 8'h00, 1'b0, V_NONE);
  endtask : sc_refuse
  task automatic sc_read();
    slow = 1'b1;
    op(OP_START, 8'h00, 1'b0, V_START);
    op(OP_WRITE, 8'hA1, 1'b0, V_MTX);
    op(OP_READ, 8'h00, 1'b1, V_MRX);
    op(OP_READ, 8'h00, 1'b1, V_MRX);
    chk("ack sent", 8'h01, {7'h0, last_ack});
    op(OP_WRITE, 8'h11, 1'b0, V_MTX);
    op(OP_READ, 8'h00, 1'b1, V_MRX);
    op(OP_RESTART, 8'h00, 1'b1, V_START);
    chk("ack sent", 8'h01, {7'h0, last_ack});
    op(OP_WRITE, 8'hA1, 1'b0, V_MTX);
    op(OP_READ, 8'h00, 1'b0, V_MRX);
    op(OP_STOP_START, 8'h00, 1'b0, V_START);
    chk("ack sent", 8'h00, {7'h0, last_ack});
    op(OP_WRITE, 8'hA1, 1'b0, V_MTX);
    op(OP_READ, 8'h00, 1'b0, V_MRX);
    op(OP_RESTART, 8'h00, 1'b0, V_START);
    chk("ack sent", 8'h00, {7'h0, last_ack});
    op(OP_WRITE, 8'hA1, 1'b0, V_MTX);
    op(OP_READ, 8'h00, 1'b0, V_MRX);
    op(OP_STOP, 8'h00, 1'b0, V_NONE);
    chk("ack sent", 8'h00, {7'h0, last_ack});
    slow = 1'b0;
  endtask : sc_read
  task automatic sc_buffer();
    rx_ready = 1'b0;
    op(OP_START, 8'h00, 1'b0, V_START);
    op(OP_WRITE, 8'hA1, 1'b0, V_MTX);
    op(OP_READ, 8'h00, 1'b1, V_MRX);
    op(OP_READ, 8'h00, 1'b1, V_MRX);
    chk("rx valid", 8'h01, {7'h0, rx_valid});
    send(OP_READ, 8'h00, 1'b1);
    // full buffer must hold the bus, not drop the third byte
    repeat (300) @(negedge clk);
    chk("stalled", 8'h00, {7'h0, cmd_ready});
    rx_ready = 1'b1;
    wait_rdy();
    chk("status", {4'h0, V_MRX}, {4'h0, status});
    op(OP_STOP, 8'h00, 1'b0, V_NONE);
  endtask : sc_buffer
  task automatic sc_faults();
    int e0;
    nack = 1'b1;
    op(OP_START, 8'h00, 1'b0, V_START);
    op(OP_WRITE, 8'hA0, 1'b0, V_MTX);
    chk("tx nack", 8'h01, {7'h0, tx_nack});
    nack = 1'b0;
    op(OP_STOP, 8'h00, 1'b0, V_NONE);
    arb = 1'b1;
    e0 = err_seen;
    send(OP_START, 8'h00, 1'b0);
    wait_rdy();
    // err pulse is counted at the next rising edge
    @(negedge clk);
    chk("arb err", 8'(e0 + 1), 8'(err_seen));
    chk("busy", 8'h00, {7'h0, busy});
    arb = 1'b0;
  endtask : sc_faults
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    sc_write();
    sc_restart();
    sc_refuse();
    sc_read();
    sc_buffer();
    sc_faults();
    chk("data access", 8'h00, {7'h0, bad});
    chk("bytes read", 8'h09, 8'(rx_k));
    wrap_up();
  end
endmodule : smsq_ctrl_bench
